// >>> chopped_sinc3_decimator.sv
`timescale 1ns/1ps
module chopped_sinc3_decimator
  import sinc3_pkg::*;
(
  input  wire logic       core_clk,     // 200 MHz core clock
  input  wire logic       rst_n,        // Async reset pin
  input  wire logic       sclk,         // Serial clock pin
  input  wire logic       cs_n,         // Chip select pin
  input  wire logic       din,          // Serial data in
  input  wire logic       mod_clk,      // Modulator sample clock
  input  wire logic       mod_bit,      // Comparator bit
  output logic            dout,         // Serial data out
  output logic            dout_oe,      // High while driving dout
  output logic            rdy_n,        // Result ready, low active
  output logic            chop_swap,    // Input mux polarity swap
  output logic [2:0]      range_sel,    // Input range code
  output logic            single_ended, // Four inputs vs common
  output logic [1:0]      chan_sel      // Selected input
);

  // All state of the block in one record
  typedef struct packed {
    logic                sclk_s1, sclk_s2, sclk_q;
    logic                cs_s1, cs_s2;
    logic                din_s1, din_s2;
    logic                mclk_s1, mclk_s2, mclk_q;
    logic                mbit_s1, mbit_s2;
    ser_state_e          st;
    logic [4:0]          bit_cnt;
    logic [4:0]          len;
    logic                rd;
    logic [1:0]          sel;
    logic [15:0]         sh_in;
    logic [15:0]         sh_out;
    logic                dout;
    logic                oe;
    logic [7:0]          ctrl;
    logic [7:0]          filt;
    logic [ACC_W-1:0]    i1, i2, i3;
    logic [ACC_W-1:0]    d1, d2, d3;
    logic [DEC_W-1:0]    dec_cnt;
    logic [1:0]          phase;
    logic                chop;
    logic [DATA_W-1:0]   prev;
    logic                have_prev;
    logic [DATA_W-1:0]   data;
    logic [DATA_W-1:0]   pend;
    logic                pend_v;
    logic                unread;
    logic                rdy_n;
  } state_s;

  state_s q_reg;   // Registered state
  state_s q_next;  // Next state

  // Edge detect on second and third sync stages only
  logic                sclk_rise, sclk_fall, mod_tick;
  logic [DEC_W-1:0]    dec_len;      // Eight times filter word
  logic [ACC_W-1:0]    full_scale;   // dec_len cubed
  logic [4:0]          out_sh;       // Truncation shift
  logic                dec_end, word_tick;
  logic [ACC_W-1:0]    c1, c2, c3;   // Differentiator outputs
  logic [ACC_W-1:0]    c3_sh;
  logic [DATA_W-1:0]   raw_word;
  logic [DATA_W:0]     avg_sum;
  logic [DATA_W-1:0]   avg_word;
  logic                mod_in;
  logic                rd_data, rd_done, rd_busy;
  logic [7:0]          cmd_byte;

  // Smallest shift bringing full scale into 16 bits
  function automatic logic [4:0] fit_shift(input logic [ACC_W-1:0] fs);
    int i;
    fit_shift = 5'h00;
    for (i = 0; i < SHIFT_MAX; i++) begin
      if ((fs >> i) > WORD_LIMIT) begin
        fit_shift = 5'(i + 1);
      end
    end
  endfunction : fit_shift

  assign sclk_rise  = q_reg.sclk_s2 & ~q_reg.sclk_q;
  assign sclk_fall  = ~q_reg.sclk_s2 & q_reg.sclk_q;
  assign mod_tick   = q_reg.mclk_s2 & ~q_reg.mclk_q;
  assign dec_len    = {q_reg.filt, 3'b000};
  assign full_scale = ACC_W'(dec_len) * ACC_W'(dec_len) * ACC_W'(dec_len);
  assign out_sh     = fit_shift(full_scale);
  // Last sample of a decimation period
  assign dec_end    = (q_reg.dec_cnt == dec_len - 11'h001);
  // Only the third word of each chop phase is settled
  assign word_tick  = mod_tick & dec_end & (q_reg.phase == LAST_PHASE);
  // Comb section, three stages at the decimated rate
  assign c1         = q_reg.i3 - q_reg.d1;
  assign c2         = c1 - q_reg.d2;
  assign c3         = c2 - q_reg.d3;
  assign c3_sh      = c3 >> out_sh;
  // Clamp any code above 16 bits; full scale itself fits after out_sh
  assign raw_word   = (c3_sh > WORD_LIMIT) ? 16'hFFFF : c3_sh[DATA_W-1:0];
  // Offsets of opposite sign cancel in the mean
  assign avg_sum    = {1'b0, raw_word} + {1'b0, q_reg.prev};
  assign avg_word   = avg_sum[DATA_W:1];
  // Output chop undone on the bitstream
  assign mod_in     = q_reg.mbit_s2 ^ q_reg.chop;
  assign rd_data    = (q_reg.st == ST_XFER) & q_reg.rd & (q_reg.sel == REG_DATA)
                      & ~q_reg.cs_s2;
  assign rd_done    = rd_data & sclk_rise & (q_reg.bit_cnt == q_reg.len - 5'h01);
  assign rd_busy    = rd_data & ~rd_done;
  assign cmd_byte   = {q_reg.sh_in[6:0], q_reg.din_s2};

  // Next-state logic for the whole block
  always_comb begin
    q_next = q_reg;
    // Two-stage synchronisers for every pin except core_clk and rst_n
    q_next.sclk_s1 = sclk;
    q_next.sclk_s2 = q_reg.sclk_s1;
    q_next.sclk_q  = q_reg.sclk_s2;
    q_next.cs_s1   = cs_n;
    q_next.cs_s2   = q_reg.cs_s1;
    q_next.din_s1  = din;
    q_next.din_s2  = q_reg.din_s1;
    q_next.mclk_s1 = mod_clk;
    q_next.mclk_s2 = q_reg.mclk_s1;
    q_next.mclk_q  = q_reg.mclk_s2;
    q_next.mbit_s1 = mod_bit;
    q_next.mbit_s2 = q_reg.mbit_s1;

    // Sinc3 filter, runs on each modulator sample
    if (mod_tick) begin
      // Integrators at the modulator rate, wide enough for 2040 cubed
      q_next.i1 = q_reg.i1 + ACC_W'(mod_in);
      // Unpipelined cascade, so a restart settles in three periods
      q_next.i2 = q_reg.i2 + q_next.i1;
      q_next.i3 = q_reg.i3 + q_next.i2;
      if (dec_end) begin
        // Decimation point, feed comb delays
        q_next.dec_cnt = '0;
        q_next.d1      = q_reg.i3;
        q_next.d2      = c1;
        q_next.d3      = c2;
        q_next.phase   = (q_reg.phase == LAST_PHASE) ? 2'h0 : q_reg.phase + 2'h1;
      end else begin
        q_next.dec_cnt = q_reg.dec_cnt + 11'h001;
      end
    end

    // Read of the data register completes
    if (rd_done) begin
      q_next.unread = 1'b0;
      if (q_reg.pend_v) begin
        // Deferred result now lands
        q_next.data   = q_reg.pend;
        q_next.unread = 1'b1;
        q_next.pend_v = 1'b0;
      end
    end

    // New filter word: chop flips, average formed
    if (word_tick) begin
      if (q_reg.ctrl[CTRL_CHOP]) begin
        q_next.chop = ~q_reg.chop;
      end
      q_next.prev      = raw_word;
      q_next.have_prev = 1'b1;
      // First word after a restart is never published
      if (q_reg.have_prev) begin
        if (rd_busy) begin
          // Data register frozen during a read
          q_next.pend   = avg_word;
          q_next.pend_v = 1'b1;
        end else begin
          // Set wins over a same-cycle read clear
          q_next.data   = avg_word;
          q_next.unread = 1'b1;
        end
      end
    end

    // Serial engine
    if (q_reg.cs_s2) begin
      // Deselected: release dout, back to command phase
      q_next.st      = ST_CMD;
      q_next.bit_cnt = '0;
      q_next.oe      = 1'b0;
    end else begin
      q_next.oe = 1'b1;
      // Edges only, so burst or gated clocks both work
      if (sclk_fall && q_reg.st == ST_XFER && q_reg.rd) begin
        q_next.dout   = q_reg.sh_out[15];
        q_next.sh_out = {q_reg.sh_out[14:0], 1'b0};
      end
      if (sclk_rise) begin
        q_next.sh_in   = {q_reg.sh_in[14:0], q_reg.din_s2};
        q_next.bit_cnt = q_reg.bit_cnt + 5'h01;
        case (q_reg.st)
          ST_CMD: begin
            if (q_reg.bit_cnt == CMD_LAST_BIT) begin
              q_next.bit_cnt = '0;
              // Idle byte, comm target or data write: stay put
              if (!cmd_byte[CMD_START] && cmd_byte[1:0] != REG_COMM &&
                  !(!cmd_byte[CMD_READ] && cmd_byte[1:0] == REG_DATA)) begin
                q_next.st  = ST_XFER;
                q_next.rd  = cmd_byte[CMD_READ];
                q_next.sel = cmd_byte[1:0];
                q_next.len = (cmd_byte[1:0] == REG_DATA) ? LEN_WORD : LEN_BYTE;
                // Left-align the chosen register for shifting out
                case (cmd_byte[1:0])
                  REG_CTRL: q_next.sh_out = {q_reg.ctrl, 8'h00};
                  REG_FILT: q_next.sh_out = {q_reg.filt, 8'h00};
                  default:  q_next.sh_out = q_reg.data;
                endcase
              end
            end
          end
          ST_XFER: begin
            if (q_reg.bit_cnt == q_reg.len - 5'h01) begin
              q_next.st      = ST_CMD;
              q_next.bit_cnt = '0;
              if (!q_reg.rd) begin
                // Control writes and filter words of at least FILT_MIN land in the selected register, then restart
                if (q_reg.sel == REG_CTRL) begin
                  q_next.ctrl = cmd_byte;
                end else if (cmd_byte >= FILT_MIN) begin
                  q_next.filt = cmd_byte;
                end
                // Fresh filter so next three periods settle cleanly
                if (q_reg.sel == REG_CTRL || cmd_byte >= FILT_MIN) begin
                  q_next.i1 = '0;
                  q_next.i2 = '0;
                  q_next.i3 = '0;
                  q_next.d1 = '0;
                  q_next.d2 = '0;
                  q_next.d3 = '0;
                  q_next.dec_cnt   = '0;
                  q_next.phase     = 2'h0;
                  q_next.chop      = 1'b0;
                  q_next.have_prev = 1'b0;
                end
              end
            end
          end
          default: q_next.st = ST_CMD;
        endcase
      end
    end

    // Ready rises for the last sample before an update
    q_next.rdy_n = ~q_next.unread |
                   (q_next.phase == LAST_PHASE && q_next.have_prev &&
                    q_next.dec_cnt == dec_len - 11'h001);
  end

  // State register; reset gives the power-on state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg        <= '0;
      q_reg.sclk_s1 <= 1'b1;
      q_reg.sclk_s2 <= 1'b1;
      q_reg.sclk_q  <= 1'b1;
      q_reg.cs_s1   <= 1'b1;
      q_reg.cs_s2   <= 1'b1;
      q_reg.st      <= ST_CMD;
      q_reg.ctrl    <= CTRL_RESET;
      q_reg.filt    <= FILT_RESET;
      q_reg.data    <= DATA_RESET;
      q_reg.len     <= LEN_BYTE;
      q_reg.rdy_n   <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign dout         = q_reg.dout;
  assign dout_oe      = q_reg.oe;
  assign rdy_n        = q_reg.rdy_n;
  assign chop_swap    = q_reg.chop;
  assign range_sel    = q_reg.ctrl[CTRL_RANGE +: 3];
  assign single_ended = q_reg.ctrl[CTRL_SINGLE];
  assign chan_sel     = q_reg.ctrl[CTRL_CHAN +: 2];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Read finishing then ready clearing
  sequence s_read_end;
    rd_done && !q_reg.pend_v && !word_tick;
  endsequence
  sequence s_ready_high;
    !q_reg.unread && q_reg.rdy_n;
  endsequence

  rdy_valid_a: assert property (!q_reg.rdy_n |-> q_reg.unread)
    else $error("ready low without unread data");
  rdy_clear_a: assert property (s_read_end |=> s_ready_high)
    else $error("ready stayed low after data read");
  rdy_pre_update_a: assert property (word_tick && q_reg.have_prev |-> q_reg.rdy_n)
    else $error("ready not high before update");
  dout_release_a: assert property (q_reg.cs_s2 |=> !dout_oe)
    else $error("dout driven while deselected");
  frame_reset_a: assert property (q_reg.cs_s2 |=> q_reg.st == ST_CMD && q_reg.bit_cnt == 5'h00)
    else $error("serial engine not reset by select");
  data_hold_a: assert property (rd_busy |=> $stable(q_reg.data))
    else $error("data changed during read");
  chop_flip_a: assert property (word_tick && q_reg.ctrl[CTRL_CHOP] |=> chop_swap != $past(chop_swap))
    else $error("chop did not toggle on word");
  filt_range_a: assert property (q_reg.filt >= FILT_MIN)
    else $error("filter word below minimum");
  avg_load_a: assert property (word_tick && q_reg.have_prev && !rd_busy |=> q_reg.data == $past(avg_word))
    else $error("data not the pair average");

endmodule : chopped_sinc3_decimator

// >>> host_model.sv
`timescale 1ns/1ps
// Host on the serial pins; all pins idle high like their weak pull-ups
module host_model (
  output logic      sclk,    // Serial clock, idles high
  output logic      cs_n,    // Select, low active
  output logic      din,     // Data toward the device
  input  wire logic dout,    // Data from the device
  input  wire logic dout_oe, // Device drives dout
  input  wire logic rdy_n    // Result ready, low active
);
  logic last_bit; // Last bit seen, stands in for a released line

  // Power-on idle levels
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
    last_bit = 1'b0;
  end

  // Frame edge; settle time covers the device's pin synchronisers
  task automatic frame(input logic sel_n);
    cs_n = sel_n;
    #40;
  endtask : frame

  // MSB first, data set on the falling edge, sampled late in the high phase
  task automatic xfer(input logic [23:0] tx, input int n, input int gap, output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #24;
      sclk = 1'b1;
      #24;
      // Undriven line floats: assume the opposite of the last bit
      rx = {rx[22:0], (dout_oe ? dout : ~last_bit)};
      last_bit = rx[0];
      if (gap > 0 && i % 8 == 0) begin
        #(gap); // gated clock, byte batches
      end
    end
    // Let the last high phase pass before din idles again
    #24;
    din = 1'b1;
  endtask : xfer

  // Data read only after a fresh ready; never while ready is high
  task automatic read_data(output logic [15:0] data);
    logic [23:0] rx;
    @(negedge rdy_n);
    xfer(24'h43FFFF, 24, 0, rx);
    data = rx[15:0];
  endtask : read_data
endmodule : host_model

// >>> sinc3_pkg.sv
package sinc3_pkg;
  // Register select codes in the command byte
  localparam logic [1:0] REG_COMM     = 2'h0;
  localparam logic [1:0] REG_CTRL     = 2'h1;
  localparam logic [1:0] REG_FILT     = 2'h2;
  localparam logic [1:0] REG_DATA     = 2'h3;
  // Command byte fields
  localparam int         CMD_START    = 7;
  localparam int         CMD_READ     = 6;
  // Transfer lengths after the command byte, and the command's last bit index
  localparam logic [4:0] LEN_BYTE     = 5'h08;
  localparam logic [4:0] LEN_WORD     = 5'h10;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  // Control register fields
  localparam int         CTRL_RANGE   = 0;
  localparam int         CTRL_SINGLE  = 3;
  localparam int         CTRL_CHAN    = 4;
  localparam int         CTRL_CHOP    = 6;
  localparam logic [7:0] CTRL_RESET   = 8'h40;
  // Filter word limits and default
  localparam logic [7:0] FILT_RESET   = 8'h45;
  localparam logic [7:0] FILT_MIN     = 8'h0D;
  // Datapath widths and constants
  localparam int         ACC_W        = 36;
  localparam int         DATA_W       = 16;
  localparam int         DEC_W        = 11;
  localparam logic [1:0] LAST_PHASE   = 2'h2;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [35:0] WORD_LIMIT  = 36'h00000FFFF;
  localparam int         SHIFT_MAX    = 20;
  // Serial engine states
  typedef enum logic {ST_CMD, ST_XFER} ser_state_e;
endpackage : sinc3_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import sinc3_pkg::*;
  logic        core_clk;     // 200 MHz clock
  logic        rst_n;        // Async reset, low active
  logic        mod_clk;      // Modulator clock, 40 ns period
  logic        mod_bit;      // Modulator bit
  logic        sclk;         // Serial clock from host
  logic        cs_n;         // Select from host
  logic        din;          // Serial data to device
  logic        dout;         // Serial data from device
  logic        dout_oe;      // Device drives dout
  logic        rdy_n;        // Ready, low active
  logic        chop_swap;    // Mux swap polarity
  logic [2:0]  range_sel;    // Range code
  logic        single_ended; // Single inputs mode
  logic [1:0]  chan_sel;     // Channel code
  logic [1:0]  mod_div;      // Divider for the modulator clock
  logic [1:0]  mod_mode;     // 0 low, 1 high, 2 inverse of chop
  logic [23:0] rx;           // Last received frame
  logic [15:0] rd;           // Last data read
  logic        c_prev;       // Chop state at a previous update
  int          n_errors;     // Mismatch count
  int          cmp_count;    // Comparison count
  int          cyc;          // Core cycles run
  int          mod_cnt;      // Modulator edges run
  int          t0;           // Edge mark
  int          t1;           // Cycle mark
  // All-ones stream with word 13: 104 cubed shifted down by 5
  localparam logic [15:0] FULL_13 = 16'h8950;
  // Chopped all-ones stream: a full word paired with a zero word
  localparam logic [15:0] HALF_13 = 16'h44A8;

  chopped_sinc3_decimator uut (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .mod_clk(mod_clk), .mod_bit(mod_bit), .dout(dout), .dout_oe(dout_oe),
    .rdy_n(rdy_n), .chop_swap(chop_swap), .range_sel(range_sel),
    .single_ended(single_ended), .chan_sel(chan_sel));
  host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .rdy_n(rdy_n));

  // Core clock
  always #2.5 core_clk = ~core_clk;

  // Modulator clock and bit; mode 2 mimics a swapped full-scale input
  always @(negedge core_clk) begin
    mod_div <= mod_div + 2'h1;
    if (mod_div == 2'h3) begin
      mod_clk <= ~mod_clk;
    end
    mod_bit <= (mod_mode == 2'h2) ? ~chop_swap : mod_mode[0];
  end

  // Edge count on the pin, same view the device samples
  always @(posedge mod_clk) mod_cnt++;

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Window check; the synchronisers blur each edge by a sample or so
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  // Register write: command byte then one byte
  task automatic wr(input logic [1:0] sel, input logic [7:0] val);
    host.xfer({8'h00, 6'h00, sel, val}, 16, 0, rx);
  endtask : wr

  // Reset held 5 cycles; outputs idle during and after it
  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("reset outputs", 16'h0080, {7'h00, dout, dout_oe, rdy_n, chop_swap, range_sel,
        single_ended, chan_sel});
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("released outputs", 16'h0080, {7'h00, dout, dout_oe, rdy_n, chop_swap, range_sel,
        single_ended, chan_sel});
  endtask : do_reset

  // Unselected write, aborted frame, then a gated write and readbacks
  task automatic t_ctrl();
    host.xfer(24'h00017F, 16, 0, rx);
    chk("unselected write", 16'h0000, {13'h0000, range_sel});
    host.frame(1'b0);
    host.xfer(24'h000017, 12, 0, rx);
    host.frame(1'b1);
    host.frame(1'b0);
    host.xfer(24'h00011D, 16, 200, rx);
    chk("control ports", 16'h001D, {9'h000, chop_swap, chan_sel, single_ended,
        range_sel});
    host.xfer(24'h0041FF, 16, 0, rx);
    chk("control readback", 16'h001D, {8'h00, rx[7:0]});
    host.xfer(24'h0042FF, 16, 0, rx);
    chk("filter default", 16'h0045, {8'h00, rx[7:0]});
  endtask : t_ctrl

  // Settling, word period, early ready rise, low filter word refused
  task automatic t_rate();
    wr(REG_FILT, 8'h0D);
    t0 = mod_cnt;
    @(negedge rdy_n);
    chk_rng("settle edges", 620, 628, mod_cnt - t0);
    t0 = mod_cnt;
    @(posedge rdy_n);
    t1 = cyc;
    @(negedge rdy_n);
    chk_rng("word edges", 311, 313, mod_cnt - t0);
    chk_rng("early rise", 4, 14, cyc - t1);
    t0 = mod_cnt;
    wr(REG_FILT, 8'h0C);
    host.xfer(24'h0042FF, 16, 0, rx);
    chk("filter low write", 16'h000D, {8'h00, rx[7:0]});
    @(negedge rdy_n);
    chk_rng("no restart", 311, 313, mod_cnt - t0);
  endtask : t_rate

  // Settled result for a stream, then ready released by the read
  task automatic t_data(input logic [1:0] mode, input logic [7:0] ctrl,
                        input logic [15:0] exp, input logic [15:0] mask);
    mod_mode = mode;
    wr(REG_CTRL, ctrl);
    host.read_data(rd);
    chk("data", exp, rd & mask);
    repeat (8) @(negedge core_clk);
    chk("ready after read", 16'h0001, {15'h0000, rdy_n});
  endtask : t_data

  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence; select stays low from the gated write of the control test until the mid-run reset (three-wire)
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    mod_clk = 1'b0;
    mod_bit = 1'b0;
    mod_div = 2'h0;
    mod_mode = 2'h1;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    mod_cnt = 0;
    do_reset();
    t_ctrl();
    t_rate();
    t_data(2'h1, 8'h1D, FULL_13, 16'hFFFF);
    t_data(2'h0, 8'h1D, 16'h0000, 16'hFFFF);
    t_data(2'h1, 8'h5D, HALF_13, 16'hFFFF);
    t_data(2'h2, 8'h5D, FULL_13, 16'hFFFF);
    // Sample chop off the edge that launches it
    @(negedge rdy_n);
    @(negedge core_clk);
    c_prev = chop_swap;
    @(negedge rdy_n);
    @(negedge core_clk);
    chk("chop toggle", {15'h0000, ~c_prev}, {15'h0000, chop_swap});
    host.frame(1'b1);
    do_reset();
    // Registers back at their power-on values after a mid-run reset
    host.frame(1'b0);
    host.xfer(24'h0042FF, 16, 0, rx);
    chk("filter after reset", 16'h0045, {8'h00, rx[7:0]});
    host.xfer(24'h0041FF, 16, 0, rx);
    chk("control after reset", 16'h0040, {8'h00, rx[7:0]});
    report_and_stop();
  end
endmodule : tb
